// file: verilog/asd_cfg.svh
// Constants for the add-and-shift datapath: opcode fields, flag positions, reset values
`ifndef ASD_CFG_SVH
`define ASD_CFG_SVH
`define ASD_OP_PTR_ADD 14'h3100
`define ASD_OP_PTR_MASK 14'h3f80
`define ASD_OP_ANDL 14'h3900
`define ASD_OP_ADDL 14'h3e00
`define ASD_OP_LIT_MASK 14'h3f00
`define ASD_OP_ANDF 14'h0500
`define ASD_OP_ADDF 14'h0700
`define ASD_OP_ARITH_SHIFT_RIGHT_FILE 14'h3700
`define ASD_OP_ADDC 14'h3d00
`define ASD_OP_FILE_MASK 14'h3f00
`define ASD_ACC_RESET 8'h00
`define ASD_PTR_RESET 16'h0000
`define ASD_FLAG_C 0
`define ASD_FLAG_DC 1
`define ASD_FLAG_Z 2
`define ASD_IND0_ADDR 7'h00
`define ASD_IND1_ADDR 7'h01
`define ASD_EXTRA_CYCLES 1
`endif

// file: verilog/asd_pkg.sv
// Types shared by the add-and-shift datapath
package asd_pkg;
   typedef enum logic [2:0] {
      ASD_NONE, ASD_PTR_ADD, ASD_ANDL, ASD_ADDL, ASD_ANDF, ASD_ADDF, ASD_ARITH_SHIFT_RIGHT_FILE, ASD_ADDC
   } asd_op_e;
   typedef enum {ASD_IDLE, ASD_STALL} asd_state_e;
endpackage

// file: verilog/asd_adder.sv
// Eight-bit adder giving sum, carry out of bit 7 and carry out of bit 3
`timescale 1ns/1ps
`default_nettype none
module asd_adder (
   input wire logic [7:0] a,  // First operand
   input wire logic [7:0] b,  // Second operand
   input wire logic cin,      // Carry in
   output logic [7:0] sum,    // Eight-bit sum
   output logic cout,         // Carry out of bit 7
   output logic dcout         // Carry out of bit 3
);
   logic [4:0] lowSum;
   logic [4:0] highSum;
   // Split at the nibble so digit carry falls out directly
   assign lowSum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
   assign highSum = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lowSum[4]};
   assign sum = {highSum[3:0], lowSum[3:0]};
   assign cout = highSum[4];  // RQ13
   assign dcout = lowSum[4];  // RQ12
endmodule
`default_nettype wire

// file: verilog/asd_datapath.sv
// Execution datapath for the add, AND, pointer-add and shift instruction group
`timescale 1ns/1ps
`default_nettype none
`include "asd_cfg.svh"

// Functional notes
// RQ1 - Pointer add: signed 6-bit literal, flags unchanged
// RQ2 - Pointer wraps modulo 65536
// RQ3 - AND literal into accumulator, zero only
// RQ4 - Add literal into accumulator, C DC Z
// RQ5 - AND accumulator with file, zero only
// RQ6 - Destination bit: 0 accumulator, 1 file
// RQ7 - Add accumulator and file, C DC Z
// RQ8 - Shift right, old bit 0 to carry
// RQ9 - Shift keeps bit 7, writes destination
// RQ10 - Add with carry, C DC Z
// RQ11 - Indirect access with pointer MSb: extra cycle
// RQ12 - Zero when result zero; digit carry bit 3
// RQ13 - Carry is carry out of bit 7
module asd_datapath
   import asd_pkg::*;
#(
   parameter int DATA_W = 8,  // Data width
   parameter int PTR_W = 16   // Indirect pointer width
) (
   input wire logic core_clk,          // Core instruction clock
   input wire logic rst,               // Synchronous reset, active high
   input wire logic instrValid,        // Instruction word present this cycle
   input wire logic [13:0] instrWord,  // Fourteen-bit instruction
   input wire logic [7:0] fileRdData,  // Addressed data register contents
   output logic [6:0] fileAddr,        // Data register address
   output logic [7:0] fileWrData,      // Result written back to file
   output logic fileWrEn,              // File write strobe
   output logic [7:0] accOut,          // Accumulator
   output logic carryOut,              // Carry flag
   output logic digitCarryOut,         // Digit carry flag
   output logic zeroOut,               // Zero flag
   output logic [15:0] pointer0Out,    // Indirect pointer 0
   output logic [15:0] pointer1Out,    // Indirect pointer 1
   output logic busy                   // Extra stall cycle in progress
);
   // Extra cycles spent on an indirect access through a high pointer
   localparam int STALL_CYCLES = `ASD_EXTRA_CYCLES;

   // Widths are fixed by the instruction encoding
   if (DATA_W != 8 || PTR_W != 16) begin : g_bad_width
      $error("asd_datapath supports only 8-bit data and 16-bit pointers");
   end

   // Stall counter is two bits wide, so at most four extra cycles
   if (STALL_CYCLES < 1 || STALL_CYCLES > 4) begin : g_bad_stall
      $error("asd_datapath supports one to four extra stall cycles");
   end

   // Zero detect, shared by every flag update
   function automatic logic isZero(input logic [7:0] v);
      isZero = (v == 8'h00);  // RQ12
   endfunction

   // Opcode match against a mask; every decode line uses it
   function automatic logic opMatch(input logic [13:0] w, input logic [13:0] mask,
                                    input logic [13:0] code);
      opMatch = ((w & mask) == code);
   endfunction

   // Byte-oriented file operations: these read data memory and may stall
   function automatic logic isFileOp(input asd_op_e o);
      isFileOp = (o == ASD_ANDF) || (o == ASD_ADDF) || (o == ASD_ARITH_SHIFT_RIGHT_FILE) || (o == ASD_ADDC);
   endfunction

   // Literal ops always land in the accumulator; file ops follow the d bit
   function automatic logic writesAcc(input asd_op_e o, input logic toFile);
      writesAcc = (o == ASD_ANDL) || (o == ASD_ADDL) || (isFileOp(o) && !toFile);
   endfunction

   // The two indirect access ports sit at the bottom of the file space
   function automatic logic isIndirectPort(input logic [6:0] a);
      isIndirectPort = (a == `ASD_IND0_ADDR) || (a == `ASD_IND1_ADDR);
   endfunction

   // Pointer chosen by a one-bit select; pointer add and stall check share it
   function automatic logic [15:0] pickPointer(input logic sel, input logic [15:0] p0,
                                               input logic [15:0] p1);
      pickPointer = sel ? p1 : p0;
   endfunction

   // Flags each operation owns; the flag register keeps the rest
   function automatic logic [2:0] flagMask(input asd_op_e o);
      logic [2:0] m;
      m = 3'h0;
      unique case (o)
         ASD_ANDL, ASD_ANDF: begin
            m[`ASD_FLAG_Z] = 1'b1;  // RQ3 RQ5
         end
         ASD_ADDL, ASD_ADDF, ASD_ADDC: begin
            m = 3'h7;  // RQ4 RQ7 RQ10
         end
         ASD_ARITH_SHIFT_RIGHT_FILE: begin
            m[`ASD_FLAG_C] = 1'b1;  // RQ8
            m[`ASD_FLAG_Z] = 1'b1;
         end
         ASD_PTR_ADD, ASD_NONE: begin
            m = 3'h0;  // RQ1
         end
      endcase
      flagMask = m;
   endfunction

   // Architectural state and registered outputs
   logic [7:0] acc_reg;
   logic [2:0] flags_reg;
   logic [15:0] ptr0_reg;
   logic [15:0] ptr1_reg;
   logic [6:0] addr_reg;
   logic [7:0] wrData_reg;
   logic wrEn_reg;
   logic busy_reg;
   logic [1:0] stallCnt_reg;
   asd_state_e state_reg;
   asd_state_e state_next;

   // Decode and datapath nets
   asd_op_e op;
   logic destFile;
   logic [7:0] lit;
   logic [6:0] faddr;
   logic [15:0] ptrSel;
   logic [15:0] ptrSum;
   logic [7:0] addA;
   logic [7:0] addB;
   logic addCin;
   logic [7:0] addSum;
   logic addCout;
   logic addDc;
   logic [7:0] result;
   logic [2:0] flags_next;
   logic needStall;
   logic [15:0] stallPtr;
   logic execute;

   // Word layout used below, major opcode in bits 13:8:
   //   literal forms carry an 8-bit literal in bits 7:0
   //   file forms carry the d bit in bit 7 and the register in bits 6:0
   //   pointer add carries the pointer select in bit 6, a signed step in 5:0
   // Opcode decode; pointer add first, as its mask is the narrower one
   always_comb begin
      op = ASD_NONE;
      if (opMatch(instrWord, `ASD_OP_PTR_MASK, `ASD_OP_PTR_ADD)) begin
         op = ASD_PTR_ADD;
      end else if (opMatch(instrWord, `ASD_OP_LIT_MASK, `ASD_OP_ANDL)) begin
         op = ASD_ANDL;
      end else if (opMatch(instrWord, `ASD_OP_LIT_MASK, `ASD_OP_ADDL)) begin
         op = ASD_ADDL;
      end else if (opMatch(instrWord, `ASD_OP_FILE_MASK, `ASD_OP_ANDF)) begin
         op = ASD_ANDF;
      end else if (opMatch(instrWord, `ASD_OP_FILE_MASK, `ASD_OP_ADDF)) begin
         op = ASD_ADDF;
      end else if (opMatch(instrWord, `ASD_OP_FILE_MASK, `ASD_OP_ARITH_SHIFT_RIGHT_FILE)) begin
         op = ASD_ARITH_SHIFT_RIGHT_FILE;
      end else if (opMatch(instrWord, `ASD_OP_FILE_MASK, `ASD_OP_ADDC)) begin
         op = ASD_ADDC;
      end
   end

   assign destFile = instrWord[7];  // RQ6
   assign lit = instrWord[7:0];
   assign faddr = instrWord[6:0];

   // Sign-extend the 6-bit literal; 16-bit sum drops overflow so it wraps
   assign ptrSel = pickPointer(instrWord[6], ptr0_reg, ptr1_reg);
   assign ptrSum = ptrSel + {{10{instrWord[5]}}, instrWord[5:0]};  // RQ1 RQ2

   // Adder operands: literal or file, carry only for add-with-carry
   always_comb begin
      addA = acc_reg;
      addB = (op == ASD_ADDL) ? lit : fileRdData;  // RQ4 RQ7
      addCin = (op == ASD_ADDC) ? flags_reg[`ASD_FLAG_C] : 1'b0;  // RQ10
   end

   asd_adder u_adder (
      .a(addA),
      .b(addB),
      .cin(addCin),
      .sum(addSum),
      .cout(addCout),
      .dcout(addDc)
   );

   // Result and flag selection per instruction
   always_comb begin
      result = acc_reg;
      flags_next = flags_reg;
      unique case (op)
         ASD_ANDL: begin
            result = acc_reg & lit;  // RQ3
            flags_next[`ASD_FLAG_Z] = isZero(result);
         end
         ASD_ANDF: begin
            result = acc_reg & fileRdData;  // RQ5
            flags_next[`ASD_FLAG_Z] = isZero(result);
         end
         ASD_ADDL, ASD_ADDF, ASD_ADDC: begin
            result = addSum;  // RQ4 RQ7 RQ10
            flags_next[`ASD_FLAG_C] = addCout;  // RQ13
            flags_next[`ASD_FLAG_DC] = addDc;  // RQ12
            flags_next[`ASD_FLAG_Z] = isZero(result);
         end
         ASD_ARITH_SHIFT_RIGHT_FILE: begin
            result = {fileRdData[7], fileRdData[7:1]};  // RQ9
            flags_next[`ASD_FLAG_C] = fileRdData[0];  // RQ8
            flags_next[`ASD_FLAG_Z] = isZero(result);
         end
         ASD_PTR_ADD, ASD_NONE: begin
            result = acc_reg;  // RQ1
         end
      endcase
   end

   // Indirect port with pointer MSb set costs extra cycles
   always_comb begin
      needStall = 1'b0;
      stallPtr = ptr0_reg;
      if (isFileOp(op) && isIndirectPort(faddr)) begin
         stallPtr = pickPointer(faddr == `ASD_IND1_ADDR, ptr0_reg, ptr1_reg);
         needStall = stallPtr[15];  // RQ11
      end
   end

   // Execute in the stall cycle, so the instruction must be held meanwhile
   always_comb begin
      state_next = state_reg;
      execute = 1'b0;
      unique case (state_reg)
         ASD_IDLE: begin
            if (instrValid && needStall) begin
               state_next = ASD_STALL;  // RQ11
            end else begin
               execute = instrValid;
            end
         end
         ASD_STALL: begin
            if (stallCnt_reg == 2'h0) begin
               state_next = ASD_IDLE;
               execute = 1'b1;  // RQ11
            end
         end
      endcase
   end

   // Stall sequencer
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= ASD_IDLE;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         busy_reg <= (state_next == ASD_STALL);
      end
   end

   // Stall length; loaded on entry, the word executes once it reaches zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stallCnt_reg <= 2'h0;
      end else if (state_reg == ASD_IDLE && state_next == ASD_STALL) begin
         stallCnt_reg <= 2'(STALL_CYCLES - 1);  // RQ11
      end else if (stallCnt_reg != 2'h0) begin
         stallCnt_reg <= stallCnt_reg - 2'h1;
      end
   end

   // Accumulator; pointer add and unknown words leave it alone
   always_ff @(posedge core_clk) begin
      if (rst) begin
         acc_reg <= `ASD_ACC_RESET;
      end else if (execute && writesAcc(op, destFile)) begin
         acc_reg <= result;  // RQ6
      end
   end

   // Flags; the mask guards flags an instruction does not own
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flags_reg <= 3'h0;
      end else if (execute) begin
         flags_reg <= (flags_next & flagMask(op)) | (flags_reg & ~flagMask(op));
      end
   end

   // Indirect pointers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ptr0_reg <= `ASD_PTR_RESET;
         ptr1_reg <= `ASD_PTR_RESET;
      end else if (execute && op == ASD_PTR_ADD) begin
         if (instrWord[6]) begin
            ptr1_reg <= ptrSum;  // RQ2
         end else begin
            ptr0_reg <= ptrSum;  // RQ2
         end
      end
   end

   // Write-back address, registered so the port comes from a flop
   always_ff @(posedge core_clk) begin
      if (rst) begin
         addr_reg <= 7'h00;
      end else begin
         addr_reg <= faddr;
      end
   end

   // Write-back data; follows the result every cycle, qualified by the strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wrData_reg <= 8'h00;
      end else begin
         wrData_reg <= result;
      end
   end

   // Write strobe: one cycle, only for file ops whose d bit is set
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wrEn_reg <= 1'b0;
      end else begin
         wrEn_reg <= execute && destFile && isFileOp(op);  // RQ6
      end
   end

   assign fileAddr = addr_reg;
   assign fileWrData = wrData_reg;
   assign fileWrEn = wrEn_reg;
   assign accOut = acc_reg;
   assign carryOut = flags_reg[`ASD_FLAG_C];
   assign digitCarryOut = flags_reg[`ASD_FLAG_DC];
   assign zeroOut = flags_reg[`ASD_FLAG_Z];
   assign pointer0Out = ptr0_reg;
   assign pointer1Out = ptr1_reg;
   assign busy = busy_reg;
endmodule
`default_nettype wire

// file: tb/asd_data_mem.sv
// Behavioural data memory facing the datapath
`timescale 1ns/1ps
`default_nettype none
module asd_data_mem (
   input wire logic clk,          // Clock
   input wire logic [6:0] rdAddr, // Read address
   output logic [7:0] rdData,     // Read data, same cycle
   input wire logic [6:0] wrAddr, // Write address
   input wire logic [7:0] wrData, // Write data
   input wire logic wrEn          // Write strobe
);
   logic [7:0] mem [128];
   // Known fill so the bench can predict every byte
   initial for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'ha5;
   assign rdData = mem[rdAddr];
   always @(posedge clk) if (wrEn) mem[wrAddr] <= wrData;
endmodule
`default_nettype wire

// file: tb/asd_datapath_properties.sv
// Assertion checker for the add-and-shift datapath
`timescale 1ns/1ps
`default_nettype none
module asd_datapath_checker (
   input wire logic core_clk, // Clock
   input wire logic rst, // Reset
   input wire logic instrValid, // Valid
   input wire logic [13:0] instrWord, // Word
   input wire logic [7:0] fileRdData, // Operand
   input wire logic [6:0] fileAddr, // Address
   input wire logic [7:0] fileWrData, // Result
   input wire logic fileWrEn, // Strobe
   input wire logic [7:0] accOut, // Accumulator
   input wire logic carryOut, // Carry
   input wire logic digitCarryOut, // Digit carry
   input wire logic zeroOut, // Zero
   input wire logic [15:0] pointer0Out, // Pointer 0
   input wire logic [15:0] pointer1Out, // Pointer 1
   input wire logic busy // Stall
);
   logic [13:0] wq;
   logic [7:0] aq, rq;
   logic [2:0] fl;
   logic [15:0] p0q, p1q;
   logic fq;
   wire logic [5:0] op = wq[13:8];
   wire logic [7:0] res = wq[7] ? fileWrData : accOut;
   wire logic isFile = instrWord[13:8] inside {6'h05, 6'h07, 6'h37, 6'h3d};
   wire logic needStall = isFile && instrWord[6:1] == 6'h00
      && (instrWord[0] ? pointer1Out[15] : pointer0Out[15]);
   // Operands at the executing edge; stalled words are left to the bench
   always_ff @(posedge core_clk) begin
      wq <= instrWord;
      aq <= accOut;
      rq <= fileRdData;
      fl <= {carryOut, digitCarryOut, zeroOut};
      p0q <= pointer0Out;
      p1q <= pointer1Out;
      fq <= !rst && instrValid && !busy && !needStall;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence stallSeq;
      busy ##1 !busy;
   endsequence
   a_ptr_add_wrap: assert property (fq && wq[13:7] == 7'h62 |->
      (wq[6] ? pointer1Out : pointer0Out) == (wq[6] ? p1q : p0q) + {{10{wq[5]}}, wq[5:0]}
      && {carryOut, digitCarryOut, zeroOut} == fl) else $error("pointer add wrong");
   a_and_lit: assert property (fq && op == 6'h39 |-> accOut == (aq & wq[7:0])
      && zeroOut == (accOut == 8'h00) && {carryOut, digitCarryOut} == fl[2:1])
      else $error("and literal wrong");
   a_add_lit: assert property (fq && op == 6'h3e |-> {carryOut, accOut} == aq + wq[7:0]
      && digitCarryOut == (5'h00 + aq[3:0] + wq[3:0] > 5'h0f) && zeroOut == (accOut == 8'h00))
      else $error("add literal wrong");
   a_and_file: assert property (fq && op == 6'h05 |-> res == (aq & rq)
      && zeroOut == (res == 8'h00) && {carryOut, digitCarryOut} == fl[2:1])
      else $error("and file wrong");
   a_dest_select: assert property (fq && op inside {6'h05, 6'h07, 6'h37, 6'h3d} |->
      fileWrEn == wq[7] && (!wq[7] || (fileAddr == wq[6:0] && accOut == aq)))
      else $error("destination wrong");
   a_add_file: assert property (fq && op == 6'h07 |-> {carryOut, res} == aq + rq
      && digitCarryOut == (5'h00 + aq[3:0] + rq[3:0] > 5'h0f) && zeroOut == (res == 8'h00))
      else $error("add file wrong");
   a_shift_sign: assert property (fq && op == 6'h37 |-> res == {rq[7], rq[7:1]}
      && carryOut == rq[0] && digitCarryOut == fl[1] && zeroOut == (res == 8'h00))
      else $error("shift wrong");
   a_add_carry: assert property (fq && op == 6'h3d |-> {carryOut, res} == aq + rq + fl[2]
      && digitCarryOut == (5'h00 + aq[3:0] + rq[3:0] + fl[2] > 5'h0f)
      && zeroOut == (res == 8'h00))
      else $error("add with carry wrong");
   a_stall_extra: assert property (instrValid && !busy && needStall |=> stallSeq)
      else $error("stall missing");
   a_no_stall: assert property (!(instrValid && needStall) |=> !busy)
      else $error("stall unexpected");
endmodule
bind asd_datapath asd_datapath_checker i_chk (.core_clk, .rst, .instrValid, .instrWord,
   .fileRdData, .fileAddr, .fileWrData, .fileWrEn, .accOut, .carryOut, .digitCarryOut,
   .zeroOut, .pointer0Out, .pointer1Out, .busy);
`default_nettype wire

// file: tb/tb_add_and_shift_datapath.sv
// Self-checking bench for the add-and-shift datapath
`timescale 1ns/1ps
`default_nettype none
module tb_add_and_shift_datapath;
   logic core_clk, rst, instrValid, midBusy, fileWrEn, carryOut, digitCarryOut, zeroOut, busy;
   logic [13:0] instrWord;
   logic [7:0] fileRdData, fileWrData, accOut;
   logic [6:0] fileAddr;
   logic [15:0] pointer0Out, pointer1Out;
   int errors, samples_checked;
   asd_datapath i_asd_datapath (.core_clk, .rst, .instrValid, .instrWord, .fileRdData,
      .fileAddr, .fileWrData, .fileWrEn, .accOut, .carryOut, .digitCarryOut, .zeroOut,
      .pointer0Out, .pointer1Out, .busy);
   asd_data_mem i_asd_data_mem (.clk(core_clk), .rdAddr(instrWord[6:0]), .rdData(fileRdData),
      .wrAddr(fileAddr), .wrData(fileWrData), .wrEn(fileWrEn));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [23:0] st();
      return {13'h0, accOut, carryOut, digitCarryOut, zeroOut};
   endfunction
   function automatic logic [23:0] ex(input logic [7:0] a, input logic [2:0] f);
      return {13'h0, a, f};
   endfunction
   // Stalled words are held one more edge, as the indirect access needs
   task automatic run(input logic [13:0] w, input logic stall);
      @(posedge core_clk);
      instrValid <= 1'b1;
      instrWord <= w;
      @(posedge core_clk);
      if (stall) begin
         #1 midBusy = busy;
         @(posedge core_clk);
      end
      instrValid <= 1'b0;
      #1;
   endtask
   task end_of_test;
      if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Memory byte at address a starts as a xor a5
   initial begin
      errors = 0;
      samples_checked = 0;
      rst = 1'b1;
      instrValid = 1'b0;
      instrWord = 14'h0000;
      midBusy = 1'b0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      #1 chk("reset", st(), ex(8'h00, 3'b000));
      run(14'h3eff, 1'b0);
      chk("addl", st(), ex(8'hff, 3'b000));
      run(14'h3e81, 1'b0);
      chk("addl", st(), ex(8'h80, 3'b110));
      run(14'h397f, 1'b0);
      chk("andl", st(), ex(8'h00, 3'b111));
      run(14'h313f, 1'b0);
      chk("ptr0", pointer0Out, 16'hffff);
      chk("flags", st(), ex(8'h00, 3'b111));
      run(14'h3d00, 1'b1);
      chk("midbusy", midBusy, 1'b1);
      chk("addc", st(), ex(8'ha6, 3'b000));
      run(14'h3101, 1'b0);
      chk("ptr0", pointer0Out, 16'h0000);
      run(14'h315f, 1'b0);
      chk("ptr1", pointer1Out, 16'h001f);
      run(14'h0500, 1'b0);
      chk("busy", busy, 1'b0);
      chk("andf", st(), ex(8'ha4, 3'b000));
      run(14'h07a1, 1'b0);
      chk("addf", st(), ex(8'ha4, 3'b100));
      chk("wr", {fileWrEn, fileAddr, fileWrData}, {1'b1, 7'h21, 8'h28});
      run(14'h3721, 1'b0);
      chk("arith_shift_right_file", st(), ex(8'h14, 3'b000));
      run(14'h37a2, 1'b0);
      chk("arith_shift_right_file", st(), ex(8'h14, 3'b100));
      chk("wr", {fileWrEn, fileAddr, fileWrData}, {1'b1, 7'h22, 8'hc3});
      run(14'h3d4e, 1'b0);
      chk("addc", st(), ex(8'h00, 3'b111));
      end_of_test();
   end
   // Watchdog well beyond the 29 cycles the sequence needs
   initial begin
      repeat (500) @(posedge core_clk);
      errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
